// file: core/prox_light_i2c_slave.sv
// Bus slave framing, threshold/offset registers and threshold interrupts of the sensor
`timescale 1ns/1ps
// Operation
// - Two 12-bit proximity thresholds, high nibble zero
// - Two 16-bit light thresholds, high resets ones
// - 10-bit proximity offset, upper six bits ignored
// - Reported proximity equals raw minus offset, zero when offset exceeds raw
// - Read-only fixed maker identification byte
// - Answer only slave address 0111000
// - First write byte is acknowledged register pointer
// - Pointer-only write just moves the pointer
// - Store each data byte aimed at 4Bh-54h, acknowledge, advance
// - Write pointer wraps from 54h to 40h
// - Read returns successive bytes until NACK, stop
// - Read pointer wraps from 54h to 40h
// - Hysteresis mode: set above high, clear below low
// - Light interrupt when visible result outside range
module prox_light_i2c_slave
	import prox_light_pkg::*;
#(
	parameter logic [7:0] MAKER_ID = 8'h5A  // Arbitrary value
)
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// Bus pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	// Measurement engine
	input  wire meas_t       meas,
	input  wire logic [1:0]  prox_int_mode,
	// Results
	output logic [11:0]      prox_result,
	output logic             prox_interrupt,
	output logic             light_interrupt
);

	core_t       q;
	core_t       next_q;
	logic [11:0] prox_high;
	logic [11:0] prox_low;
	logic [15:0] light_high;
	logic [15:0] light_low;
	logic [11:0] prox_offset;
	logic [11:0] prox_diff;
	logic        prox_above;
	logic        prox_below;
	logic        prox_outside;
	logic        light_outside;

	// Threshold and offset views of the register bank
	assign prox_high   = {q.regs[I_PROX_HIGH + 1][3:0], q.regs[I_PROX_HIGH]};
	assign prox_low    = {q.regs[I_PROX_LOW + 1][3:0], q.regs[I_PROX_LOW]};
	assign light_high  = {q.regs[I_LIGHT_HIGH + 1], q.regs[I_LIGHT_HIGH]};
	assign light_low   = {q.regs[I_LIGHT_LOW + 1], q.regs[I_LIGHT_LOW]};
	assign prox_offset = {2'h0, q.regs[I_OFFSET + 1][1:0], q.regs[I_OFFSET]};

	// Offset larger than the raw count clamps to zero rather than wrapping
	assign prox_diff = (meas.raw_prox >= prox_offset) ? meas.raw_prox - prox_offset : 12'h000;

	threshold_window #(
		.WIDTH (12)
	) u_prox_window (
		.value   (prox_diff),
		.upper   (prox_high),
		.lower   (prox_low),
		.above   (prox_above),
		.below   (prox_below),
		.outside (prox_outside)
	);

	threshold_window #(
		.WIDTH (16)
	) u_light_window (
		.value   (meas.visible),
		.upper   (light_high),
		.lower   (light_low),
		.above   (),
		.below   (),
		.outside (light_outside)
	);

	// Outputs
	assign sda_out         = 1'b0;
	assign sda_oe_n        = ~q.drive;
	assign prox_result     = q.prox_result;
	assign prox_interrupt  = q.prox_int;
	assign light_interrupt = q.light_int;

	// Pointer step; the sensor block wraps, other addresses just count up
	function automatic logic [7:0] step_ptr(input logic [7:0] p);
		if (p == PTR_LAST)
		begin
			step_ptr = PTR_FIRST;
		end
		else
		begin
			step_ptr = p + 8'h01;
		end
	endfunction

	function automatic logic in_bank(input logic [7:0] p);
		in_bank = (p >= OFF_PROX_HIGH_LO) && (p <= OFF_OFFSET_HI);
	endfunction

	function automatic logic [3:0] bank_idx(input logic [7:0] p);
		logic [7:0] rel;
		rel      = p - OFF_PROX_HIGH_LO;
		bank_idx = rel[3:0];
	endfunction

	// Read view; unmapped offsets read as zero
	function automatic logic [7:0] read_byte(input core_t s, input logic [7:0] p);
		read_byte = 8'h00;
		if (in_bank(p))
		begin
			read_byte = s.regs[bank_idx(p)];
		end
		else
		begin
			case (p)
				OFF_PROX_RESULT_LO:  read_byte = s.prox_result[7:0];
				OFF_PROX_RESULT_HI:  read_byte = {4'h0, s.prox_result[11:8]};
				OFF_LIGHT_RESULT_LO: read_byte = meas.visible[7:0];
				OFF_LIGHT_RESULT_HI: read_byte = meas.visible[15:8];
				OFF_MAKER_ID:        read_byte = MAKER_ID;
				default:             read_byte = 8'h00;
			endcase
		end
	endfunction

	always_comb
	begin
		logic start_seen;
		logic stop_seen;
		logic scl_rise;
		logic scl_fall;
		logic [7:0] fetched;
		start_seen = 1'b0;
		stop_seen  = 1'b0;
		scl_rise   = 1'b0;
		scl_fall   = 1'b0;
		fetched    = 8'h00;
		next_q     = q;

		next_q.scl_q = scl_in;
		next_q.sda_q = sda_in;
		scl_rise     = scl_in & ~q.scl_q;
		scl_fall     = ~scl_in & q.scl_q;
		start_seen   = q.scl_q & scl_in & q.sda_q & ~sda_in;
		stop_seen    = q.scl_q & scl_in & ~q.sda_q & sda_in;

		// Result and interrupt tracking
		next_q.prox_result = prox_diff;
		if (meas.done)
		begin
			case (prox_int_mode)
				MODE_HIGH_ONLY:
				begin
					next_q.prox_int = prox_above;
				end
				MODE_HYSTERESIS:
				begin
					if (prox_above)
					begin
						next_q.prox_int = 1'b1;
					end
					else if (prox_below)
					begin
						next_q.prox_int = 1'b0;
					end
				end
				MODE_OUTSIDE:
				begin
					next_q.prox_int = prox_outside;
				end
				default:
				begin
					next_q.prox_int = q.prox_int;
				end
			endcase
			next_q.light_int = light_outside;
		end

		// Bus framing
		if (stop_seen)
		begin
			next_q.st    = BUS_IDLE;
			next_q.drive = 1'b0;
		end
		else if (start_seen)
		begin
			// Also a repeated start: pointer survives into the read
			next_q.st     = BUS_ADDR;
			next_q.bitcnt = 4'h0;
			next_q.drive  = 1'b0;
		end
		else
		begin
			case (q.st)
				BUS_IDLE:
				begin
					next_q.drive = 1'b0;
				end
				BUS_ADDR:
				begin
					if (scl_rise)
					begin
						next_q.shift  = {q.shift[6:0], sda_in};
						next_q.bitcnt = q.bitcnt + 4'h1;
					end
					else if (scl_fall && q.bitcnt == BYTE_BITS)
					begin
						if (q.shift[7:1] == SLAVE_ADDR)
						begin
							next_q.drive = 1'b1;
							next_q.rw    = q.shift[0];
							next_q.st    = BUS_ADDR_ACK;
						end
						else
						begin
							next_q.st = BUS_IDLE;
						end
					end
				end
				BUS_ADDR_ACK:
				begin
					if (scl_fall)
					begin
						next_q.bitcnt = 4'h0;
						if (q.rw)
						begin
							fetched      = read_byte(q, q.ptr);
							next_q.tx    = fetched;
							next_q.drive = ~fetched[7];
							next_q.st    = BUS_RD_BYTE;
						end
						else
						begin
							next_q.drive = 1'b0;
							next_q.first = 1'b1;
							next_q.st    = BUS_WR_BYTE;
						end
					end
				end
				BUS_WR_BYTE:
				begin
					if (scl_rise)
					begin
						next_q.shift  = {q.shift[6:0], sda_in};
						next_q.bitcnt = q.bitcnt + 4'h1;
					end
					else if (scl_fall && q.bitcnt == BYTE_BITS)
					begin
						next_q.drive = 1'b1;
						next_q.st    = BUS_WR_ACK;
						if (q.first)
						begin
							// A stop after this byte leaves only the pointer changed
							next_q.ptr = q.shift;
						end
						else
						begin
							if (in_bank(q.ptr))
							begin
								next_q.regs[bank_idx(q.ptr)] = q.shift & REG_MASK[bank_idx(q.ptr)];
							end
							next_q.ptr = step_ptr(q.ptr);
						end
					end
				end
				BUS_WR_ACK:
				begin
					if (scl_fall)
					begin
						next_q.drive  = 1'b0;
						next_q.first  = 1'b0;
						next_q.bitcnt = 4'h0;
						next_q.st     = BUS_WR_BYTE;
					end
				end
				BUS_RD_BYTE:
				begin
					if (scl_fall)
					begin
						if (q.bitcnt == LAST_BIT)
						begin
							next_q.drive = 1'b0;
							next_q.st    = BUS_RD_ACK;
						end
						else
						begin
							next_q.tx     = {q.tx[6:0], 1'b0};
							next_q.drive  = ~q.tx[6];
							next_q.bitcnt = q.bitcnt + 4'h1;
						end
					end
				end
				BUS_RD_ACK:
				begin
					if (scl_rise)
					begin
						next_q.nack = sda_in;
					end
					else if (scl_fall)
					begin
						next_q.ptr = step_ptr(q.ptr);
						if (q.nack)
						begin
							// Master ends the read; wait for its stop
							next_q.st = BUS_IDLE;
						end
						else
						begin
							fetched       = read_byte(q, step_ptr(q.ptr));
							next_q.tx     = fetched;
							next_q.drive  = ~fetched[7];
							next_q.bitcnt = 4'h0;
							next_q.st     = BUS_RD_BYTE;
						end
					end
				end
				default:
				begin
					next_q.st    = BUS_IDLE;
					next_q.drive = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			q.st          <= BUS_IDLE;
			q.bitcnt      <= 4'h0;
			q.shift       <= 8'h00;
			q.tx          <= 8'h00;
			q.ptr         <= PTR_RESET;
			q.rw          <= 1'b0;
			q.first       <= 1'b0;
			q.nack        <= 1'b0;
			q.drive       <= 1'b0;
			q.scl_q       <= 1'b1;
			q.sda_q       <= 1'b1;
			q.regs        <= REG_RESET;
			q.prox_result <= 12'h000;
			q.prox_int    <= 1'b0;
			q.light_int   <= 1'b0;
		end
		else
		begin
			q <= next_q;
		end
	end

endmodule

// file: core/threshold_window.sv
// Compares one result against an upper and a lower threshold
`timescale 1ns/1ps
module threshold_window
#(
	parameter int WIDTH = 16
)
(
	// Operands
	input  wire logic [WIDTH-1:0] value,
	input  wire logic [WIDTH-1:0] upper,
	input  wire logic [WIDTH-1:0] lower,
	// Verdicts
	output logic                  above,
	output logic                  below,
	output logic                  outside
);

	// Strict compares: a result equal to a threshold stays inside
	assign above   = value > upper;
	assign below   = value < lower;
	assign outside = above | below;

endmodule

// file: include/prox_light_pkg.sv
// Shared constants and types for the proximity and light sensor register front end
package prox_light_pkg;

	// Bus address and pointer walk
	localparam logic [6:0] SLAVE_ADDR    = 7'h38;
	localparam logic [7:0] PTR_FIRST     = 8'h40;
	localparam logic [7:0] PTR_LAST      = 8'h54;
	localparam logic [7:0] PTR_RESET     = 8'h40;
	localparam logic [2:0] PTR_TOP_BLOCK = 3'h2;

	// Register offsets
	localparam logic [7:0] OFF_PROX_RESULT_LO  = 8'h44;
	localparam logic [7:0] OFF_PROX_RESULT_HI  = 8'h45;
	localparam logic [7:0] OFF_LIGHT_RESULT_LO = 8'h46;
	localparam logic [7:0] OFF_LIGHT_RESULT_HI = 8'h47;
	localparam logic [7:0] OFF_PROX_HIGH_LO    = 8'h4B;
	localparam logic [7:0] OFF_PROX_HIGH_HI    = 8'h4C;
	localparam logic [7:0] OFF_PROX_LOW_LO     = 8'h4D;
	localparam logic [7:0] OFF_PROX_LOW_HI     = 8'h4E;
	localparam logic [7:0] OFF_LIGHT_HIGH_LO   = 8'h4F;
	localparam logic [7:0] OFF_LIGHT_HIGH_HI   = 8'h50;
	localparam logic [7:0] OFF_LIGHT_LOW_LO    = 8'h51;
	localparam logic [7:0] OFF_LIGHT_LOW_HI    = 8'h52;
	localparam logic [7:0] OFF_OFFSET_LO       = 8'h53;
	localparam logic [7:0] OFF_OFFSET_HI       = 8'h54;
	localparam logic [7:0] OFF_MAKER_ID        = 8'h92;

	// Writable bank runs from the first threshold byte to the offset high bits
	localparam int REG_COUNT     = 10;
	localparam int I_PROX_HIGH   = int'(OFF_PROX_HIGH_LO - OFF_PROX_HIGH_LO);
	localparam int I_PROX_LOW    = int'(OFF_PROX_LOW_LO - OFF_PROX_HIGH_LO);
	localparam int I_LIGHT_HIGH  = int'(OFF_LIGHT_HIGH_LO - OFF_PROX_HIGH_LO);
	localparam int I_LIGHT_LOW   = int'(OFF_LIGHT_LOW_LO - OFF_PROX_HIGH_LO);
	localparam int I_OFFSET      = int'(OFF_OFFSET_LO - OFF_PROX_HIGH_LO);

	// Reset values and writable-bit masks, entry 0 is the lowest offset
	localparam logic [9:0][7:0] REG_RESET = {8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
		8'hFF, 8'h00, 8'h00, 8'h0F, 8'hFF};
	localparam logic [9:0][7:0] REG_MASK  = {8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF};

	// Proximity interrupt modes
	localparam logic [1:0] MODE_HIGH_ONLY  = 2'h0;
	localparam logic [1:0] MODE_HYSTERESIS = 2'h1;
	localparam logic [1:0] MODE_OUTSIDE    = 2'h2;

	// Bit counting
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] LAST_BIT  = 4'h7;

	typedef enum logic [2:0] {
		BUS_IDLE,
		BUS_ADDR,
		BUS_ADDR_ACK,
		BUS_WR_BYTE,
		BUS_WR_ACK,
		BUS_RD_BYTE,
		BUS_RD_ACK
	} bus_state_t;

	// Results handed in by the measurement engine
	typedef struct packed {
		logic [11:0] raw_prox;
		logic [15:0] visible;
		logic        done;
	} meas_t;

	typedef struct packed {
		bus_state_t      st;
		logic [3:0]      bitcnt;
		logic [7:0]      shift;
		logic [7:0]      tx;
		logic [7:0]      ptr;
		logic            rw;
		logic            first;
		logic            nack;
		logic            drive;
		logic            scl_q;
		logic            sda_q;
		logic [9:0][7:0] regs;
		logic [11:0]     prox_result;
		logic            prox_int;
		logic            light_int;
	} core_t;

endpackage

// file: tb/host.sv
// Bus master model: drives the clock and data pins, reports each byte outcome
`timescale 1ns/1ps
module host
(
	// Clock and resolved data line
	input  wire logic sys_clk,
	input  wire logic sda,
	// Pins driven by the master
	output logic       scl,
	output logic       sda_m,
	// Outcome of each byte
	output logic       got_valid,
	output logic [7:0] got
);
	initial
	begin
		scl = 1'b1;
		sda_m = 1'b1;
		got_valid = 1'b0;
		got = 8'h00;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Data moves only with the clock low, held well clear of both clock edges
	task automatic bit_io(input logic v, output logic r);
		sda_m = v;
		tick(3);
		scl = 1'b1;
		tick(4);
		r = sda;
		scl = 1'b0;
		tick(2);
	endtask
	task automatic start();
		sda_m = 1'b1;
		tick(3);
		scl = 1'b1;
		tick(4);
		sda_m = 1'b0;
		tick(4);
		scl = 1'b0;
		tick(2);
	endtask
	task automatic stop();
		sda_m = 1'b0;
		tick(3);
		scl = 1'b1;
		tick(4);
		sda_m = 1'b1;
		tick(4);
	endtask
	task automatic xfer(input logic [7:0] w, input logic mack, input logic rd);
		logic [7:0] r;
		logic       a;
		for (int i = 7; i >= 0; i--)
			bit_io(w[i], r[i]);
		bit_io(mack, a);
		got = rd ? r : {7'h00, a};
		got_valid = 1'b1;
		tick(1);
		got_valid = 1'b0;
	endtask
	task automatic send(input logic [7:0] b);
		xfer(b, 1'b1, 1'b0);
	endtask
	task automatic recv(input logic last);
		xfer(8'hFF, last, 1'b1);
	endtask
endmodule

// file: tb/prox_light_properties.sv
// Concurrent checks on the pins of the sensor bus front end
`timescale 1ns/1ps
module prox_light_properties
	import prox_light_pkg::*;
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        nrst,
	// Bus pins
	input wire logic        scl_in,
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        sda_oe_n,
	// Measurement side
	input wire meas_t       meas,
	input wire logic [1:0]  prox_int_mode,
	input wire logic [11:0] prox_result,
	input wire logic        prox_interrupt,
	input wire logic        light_interrupt
);
	// Bits of the address byte, counted from the last start
	logic [3:0] acnt;
	logic [7:0] ash;
	logic       scl_d;
	logic       sda_d;
	always_ff @(posedge sys_clk)
	begin
		scl_d <= scl_in;
		sda_d <= sda_in;
		if (!nrst)
			acnt <= 4'h9;
		else if (scl_in && scl_d && sda_d && !sda_in)
			acnt <= 4'h0;
		else if (scl_in && !scl_d && acnt != 4'h9)
			acnt <= acnt + 4'h1;
		if (scl_in && !scl_d)
			ash <= {ash[6:0], sda_in};
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	addr_match_a: assert property (acnt == 4'h8 && !sda_oe_n |-> ash[7:1] == SLAVE_ADDR)
		else $error("foreign address acknowledged");
	addr_ack_a: assert property (acnt == 4'h8 && ash[7:1] == SLAVE_ADDR && $fell(scl_in) |-> ##[1:2] !sda_oe_n)
		else $error("own address not acknowledged");
	// A change with the clock high would read as a start or stop
	data_low_a: assert property ($changed(sda_oe_n) |-> !scl_in)
		else $error("data pin moved with clock high");
	reset_idle_a: assert property (disable iff (1'b0) !nrst |=> sda_oe_n && !prox_interrupt && !light_interrupt)
		else $error("outputs not idle after reset");
	prox_bound_a: assert property (meas.done |=> prox_result <= $past(meas.raw_prox))
		else $error("result above raw value");
	prox_clamp_a: assert property (meas.done && meas.raw_prox == 12'h000 |=> prox_result == 12'h000)
		else $error("zero raw value not reported as zero");
	light_hold_a: assert property (!meas.done && !$past(meas.done) |=> $stable(light_interrupt))
		else $error("light flag moved without a measurement");
	prox_hold_a: assert property ($stable(prox_int_mode) && !(meas.done || $past(meas.done)) |=> $stable(prox_interrupt))
		else $error("proximity flag moved without a measurement");
endmodule

bind prox_light_i2c_slave prox_light_properties prox_light_properties_inst
(
	.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .meas(meas), .prox_int_mode(prox_int_mode), .prox_result(prox_result),
	.prox_interrupt(prox_interrupt), .light_interrupt(light_interrupt)
);

// file: tb/tb.sv
// Self-checking bench for the sensor bus front end
`timescale 1ns/1ps
module tb
	import prox_light_pkg::*;
;
	localparam logic [7:0] ID_CODE = 8'h3C; // Arbitrary value
	logic        sys_clk;
	logic        nrst;
	logic        scl, sda_m, sda_in, sda_out, sda_oe_n;
	meas_t       meas;
	logic [1:0]  prox_int_mode;
	logic [11:0] prox_result;
	logic        prox_interrupt, light_interrupt, got_valid;
	logic [7:0]  got;
	logic [7:0]  expq [$];
	logic [7:0]  dat [0:11];
	logic [7:0]  bank [0:9] = '{8'hFF, 8'h0F, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  msk [0:9] = '{8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03};
	logic [7:0]  ptr = 8'h40;
	logic [11:0] pres = 12'h000;
	logic [31:0] lfsr = 32'hBF17DFDD;
	int          fail_count = 0;
	int          checks = 0;

	always #25 sys_clk = ~sys_clk;
	// Pull-up wins unless some party pulls low
	assign sda_in = sda_m & (sda_oe_n | sda_out);

	prox_light_i2c_slave #(.MAKER_ID(ID_CODE)) prox_light_i2c_slave_inst
	(
		.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.meas(meas), .prox_int_mode(prox_int_mode), .prox_result(prox_result),
		.prox_interrupt(prox_interrupt), .light_interrupt(light_interrupt)
	);
	host host_inst (.sys_clk(sys_clk), .sda(sda_in), .scl(scl), .sda_m(sda_m), .got_valid(got_valid), .got(got));

	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] step(input logic [7:0] a);
		return (a == 8'h54) ? 8'h40 : a + 8'h01;
	endfunction
	function automatic logic [7:0] model(input logic [7:0] a);
		case (a)
			8'h44: return pres[7:0];
			8'h45: return {4'h0, pres[11:8]};
			8'h46: return meas.visible[7:0];
			8'h47: return meas.visible[15:8];
			8'h92: return ID_CODE;
			default: return (a >= 8'h4B && a <= 8'h54) ? bank[a - 8'h4B] : 8'h00;
		endcase
	endfunction
	task automatic cmp(input logic [7:0] exp, input logic [7:0] act);
		checks++;
		if (act !== exp)
		begin
			fail_count++;
			$display("Error at %0t ns: got %h expected %h", $time, act, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] p, input int n, input logic keep);
		expq.push_back(8'h00);
		expq.push_back(8'h00);
		host_inst.start();
		host_inst.send(8'h70);
		host_inst.send(p);
		ptr = p;
		for (int i = 0; i < n; i++)
		begin
			expq.push_back(8'h00);
			if (ptr >= 8'h4B && ptr <= 8'h54)
				bank[ptr - 8'h4B] = dat[i] & msk[ptr - 8'h4B];
			host_inst.send(dat[i]);
			ptr = step(ptr);
		end
		if (!keep)
			host_inst.stop();
	endtask
	task automatic rd(input logic [7:0] p, input int n, input logic direct);
		if (!direct)
			wr(p, 0, 1'b1);
		expq.push_back(8'h00);
		host_inst.start();
		host_inst.send(8'h71);
		for (int i = 0; i < n; i++)
		begin
			expq.push_back(model(ptr));
			host_inst.recv(i == n - 1);
			ptr = step(ptr);
		end
		host_inst.stop();
	endtask
	task automatic measure(input logic [11:0] raw, input logic [15:0] vis, input logic [1:0] irq);
		meas = '{raw, vis, 1'b1};
		host_inst.tick(1);
		meas.done = 1'b0;
		host_inst.tick(3);
		cmp({7'h00, irq[1]}, {7'h00, prox_interrupt});
		cmp({7'h00, irq[0]}, {7'h00, light_interrupt});
		pres = (raw > 12'h010) ? raw - 12'h010 : 12'h000;
		cmp(pres[7:0], prox_result[7:0]);
		cmp({4'h0, pres[11:8]}, {4'h0, prox_result[11:8]});
		rd(8'h44, 4, 1'b0);
	endtask

	always @(posedge sys_clk)
		if (got_valid === 1'b1)
			cmp(expq.size() > 0 ? expq.pop_front() : 8'hXX, got);

	initial
	begin
		sys_clk = 1'b0;
		nrst = 1'b0;
		meas = '0;
		prox_int_mode = MODE_HYSTERESIS;
		repeat (2) @(posedge sys_clk);
		#1;
		nrst = 1'b1;
		host_inst.tick(2);
		rd(8'h4B, 12, 1'b0);
		for (int i = 0; i < 12; i++)
		begin
			lfsr = next_rand(lfsr);
			dat[i] = lfsr[7:0];
		end
		wr(8'h4B, 12, 1'b0);
		rd(8'h53, 4, 1'b0);
		expq.push_back(8'h01);
		expq.push_back(8'h01);
		host_inst.start();
		host_inst.send(8'h72);
		host_inst.send(8'h4B);
		host_inst.stop();
		rd(8'h4B, 10, 1'b0);
		wr(8'h50, 0, 1'b0);
		rd(8'h00, 2, 1'b1);
		dat[0] = 8'hFF;
		wr(8'h92, 1, 1'b0);
		rd(8'h92, 2, 1'b0);
		dat = '{8'h00, 8'hF2, 8'h00, 8'h01, 8'h00, 8'h80, 8'h00, 8'h10, 8'h10, 8'hFC, 8'h00, 8'h00};
		wr(8'h4B, 10, 1'b0);
		measure(12'h220, 16'h9000, 2'b11);
		measure(12'h180, 16'h4000, 2'b10);
		measure(12'h100, 16'h0800, 2'b01);
		measure(12'h180, 16'h8000, 2'b00);
		measure(12'h000, 16'h1000, 2'b00);
		// High-only drops between the thresholds where hysteresis would hold
		prox_int_mode = MODE_HIGH_ONLY;
		measure(12'h300, 16'h8001, 2'b11);
		measure(12'h180, 16'h8000, 2'b00);
		prox_int_mode = MODE_OUTSIDE;
		measure(12'h050, 16'h1000, 2'b10);
		measure(12'h180, 16'h0FFF, 2'b01);
		// Unused mode code keeps the last proximity verdict
		prox_int_mode = 2'h3;
		measure(12'h300, 16'h1000, 2'b00);
		results();
	end

	// About three times the expected run
	initial
	begin
		#2_000_000;
		fail_count++;
		results();
	end
endmodule
